// ==== logic/opmode_pkg.sv ====
// Constants and types for the operating-mode controller.
// Assumes one 10 MHz clock and an Avalon-MM slave with waitrequest.
package opmode_pkg;
	localparam logic [3:0] ADDR_OSC_MODE = 4'h0;
	localparam logic [3:0] ADDR_PERIPH = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam int BIT_HIGH_STOP = 1;
	localparam int BIT_SLOW_SEL = 2;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_GREEN = 4;
	localparam int BIT_WT_EN = 0;
	localparam int BIT_PB_EN = 1;
	localparam int BIT_CONV_EN = 2;
	localparam int BIT_XTAL = 3;
	localparam logic [31:0] OSC_MODE_MASK = 32'h0000_001e;
	localparam logic [31:0] PERIPH_MASK = 32'h0000_000f;
	localparam logic [1:0] CPU_NORMAL = 2'h0;
	localparam logic [1:0] CPU_SLEEP = 2'h1;
	localparam logic [1:0] CPU_GREEN = 2'h2;
	localparam int WARM_XTAL = 2048;
	localparam int WARM_RC = 32;
	localparam int SLOW_DIV = 4;
	typedef enum logic [4:0] {
		ST_NORMAL = 5'b00001,
		ST_SLOW = 5'b00010,
		ST_DOWN = 5'b00100,
		ST_GREEN = 5'b01000,
		ST_WARM = 5'b10000
	} mode_t;
	typedef struct packed {
		logic ext_high_osc;
		logic int_high_rc;
		logic int_low_rc;
	} osc_en_t;
	typedef struct packed {
		logic cpu_run;
		logic cpu_tick;
		logic wake_timer_enable;
		logic pwm_buzz_timer_enable;
		logic converter_enable;
	} gate_t;
endpackage

// ==== logic/operating_mode_controller.sv ====
// Operating-mode controller with Avalon-MM register access.
// Assumes port levels, timer overflow and low RC tick are synchronous to clock_i.
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module operating_mode_controller #(
	parameter int PORT_W = 8,
	parameter int WARM_XTAL_CYC = opmode_pkg::WARM_XTAL
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [PORT_W-1:0] wake_port_i,
	input wire logic wake_timer_ovf_i,
	input wire logic low_rc_tick_i,
	output opmode_pkg::osc_en_t osc_en_o,
	output opmode_pkg::gate_t gate_o,
	output logic [4:0] mode_o
);
	initial begin
		if (PORT_W < 1 || PORT_W > 32 || WARM_XTAL_CYC < 1 || WARM_XTAL_CYC > 65535) begin
			$error("operating_mode_controller: bad parameter");
		end
	end

	opmode_pkg::mode_t state_ff;
	opmode_pkg::mode_t nxt_state;
	logic high_stop_ff;
	logic slow_sel_ff;
	logic sleep_ff;
	logic green_ff;
	logic [3:0] periph_ff;
	logic green_from_slow_ff;
	logic [PORT_W-1:0] port_latch_ff;
	logic [15:0] warm_ff;
	logic [1:0] div_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic port_change;
	logic wake_down;
	logic wake_green;
	logic warm_done;
	logic wr_osc;
	logic wr_per;
	logic [15:0] warm_len;

	// Port wake compares live pins with the levels held at entry.
	assign port_change = (wake_port_i != port_latch_ff);
	assign wake_down = (state_ff == opmode_pkg::ST_DOWN) && port_change;
	assign wake_green = (state_ff == opmode_pkg::ST_GREEN) && (port_change || wake_timer_ovf_i);
	assign warm_len = periph_ff[opmode_pkg::BIT_XTAL] ? 16'(WARM_XTAL_CYC) : 16'(opmode_pkg::WARM_RC);
	assign warm_done = (state_ff == opmode_pkg::ST_WARM) && (warm_ff == warm_len - 16'h0001);

	// One cycle of waitrequest high, then the access completes.
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
	assign wr_osc = avs_write_i && ack_ff && avs_byteenable_i[0] && (avs_address_i == opmode_pkg::ADDR_OSC_MODE);
	assign wr_per = avs_write_i && ack_ff && avs_byteenable_i[0] && (avs_address_i == opmode_pkg::ADDR_PERIPH);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (avs_read_i || avs_write_i) && !ack_ff;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read_i && !ack_ff) begin
			unique case (avs_address_i)
				opmode_pkg::ADDR_OSC_MODE: rdata_ff <= {27'h000_0000, green_ff, sleep_ff, slow_sel_ff, high_stop_ff, 1'b0};
				opmode_pkg::ADDR_PERIPH: rdata_ff <= {28'h000_0000, periph_ff};
				opmode_pkg::ADDR_STATUS: rdata_ff <= {27'h000_0000, state_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end
	end
	assign avs_readdata_o = rdata_ff;

	// Mode request bits; the hardware clear on wake beats a software write.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			high_stop_ff <= 1'b0;
			slow_sel_ff <= 1'b0;
			sleep_ff <= 1'b0;
			green_ff <= 1'b0;
		end else begin
			if (wr_osc) begin
				high_stop_ff <= avs_writedata_i[opmode_pkg::BIT_HIGH_STOP];
				slow_sel_ff <= avs_writedata_i[opmode_pkg::BIT_SLOW_SEL];
				sleep_ff <= avs_writedata_i[opmode_pkg::BIT_SLEEP] && !avs_writedata_i[opmode_pkg::BIT_GREEN];
				green_ff <= avs_writedata_i[opmode_pkg::BIT_GREEN] && !avs_writedata_i[opmode_pkg::BIT_SLEEP];
			end
			if (wake_down) begin
				sleep_ff <= 1'b0;
				high_stop_ff <= 1'b0;
				slow_sel_ff <= 1'b0;
			end
			if (wake_green) begin
				green_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			periph_ff <= 4'h0;
		end else if (wr_per) begin
			periph_ff <= avs_writedata_i[3:0];
		end
	end

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			opmode_pkg::ST_NORMAL, opmode_pkg::ST_SLOW: begin
				if (sleep_ff) begin
					nxt_state = opmode_pkg::ST_DOWN;
				end else if (green_ff) begin
					nxt_state = opmode_pkg::ST_GREEN;
				end else if (high_stop_ff && !slow_sel_ff) begin
					nxt_state = opmode_pkg::ST_DOWN;
				end else if (slow_sel_ff) begin
					nxt_state = opmode_pkg::ST_SLOW;
				end else begin
					nxt_state = opmode_pkg::ST_NORMAL;
				end
			end
			opmode_pkg::ST_DOWN: begin
				if (wake_down) begin
					nxt_state = opmode_pkg::ST_WARM;
				end
			end
			opmode_pkg::ST_WARM: begin
				if (warm_done) begin
					nxt_state = opmode_pkg::ST_NORMAL;
				end
			end
			opmode_pkg::ST_GREEN: begin
				if (wake_green) begin
					nxt_state = green_from_slow_ff ? opmode_pkg::ST_SLOW : opmode_pkg::ST_NORMAL;
				end
			end
			default: nxt_state = opmode_pkg::ST_NORMAL;
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= opmode_pkg::ST_NORMAL;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			green_from_slow_ff <= 1'b0;
			port_latch_ff <= '0;
		end else if (state_ff != opmode_pkg::ST_DOWN && state_ff != opmode_pkg::ST_GREEN) begin
			green_from_slow_ff <= (state_ff == opmode_pkg::ST_SLOW);
			port_latch_ff <= wake_port_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			warm_ff <= 16'h0000;
		end else if (state_ff == opmode_pkg::ST_WARM) begin
			warm_ff <= warm_ff + 16'h0001;
		end else begin
			warm_ff <= 16'h0000;
		end
	end

	// Slow-mode instruction tick: one per four low RC ticks.
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			div_ff <= 2'h0;
		end else if (state_ff == opmode_pkg::ST_SLOW && low_rc_tick_i) begin
			div_ff <= div_ff + 2'h1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			osc_en_o <= '{ext_high_osc: 1'b1, int_high_rc: 1'b1, int_low_rc: 1'b1};
			gate_o <= '0;
			mode_o <= opmode_pkg::ST_NORMAL;
		end else begin
			mode_o <= nxt_state;
			unique case (nxt_state)
				opmode_pkg::ST_DOWN: begin
					osc_en_o <= '0;
					gate_o <= '0;
				end
				opmode_pkg::ST_WARM: begin
					osc_en_o <= '{ext_high_osc: 1'b1, int_high_rc: 1'b1, int_low_rc: 1'b1};
					gate_o <= '0;
				end
				default: begin
					osc_en_o.ext_high_osc <= !high_stop_ff;
					osc_en_o.int_high_rc <= !high_stop_ff;
					osc_en_o.int_low_rc <= 1'b1;
					gate_o.cpu_run <= (nxt_state != opmode_pkg::ST_GREEN);
					gate_o.cpu_tick <= (nxt_state == opmode_pkg::ST_NORMAL) ||
						(nxt_state == opmode_pkg::ST_SLOW && low_rc_tick_i && div_ff == 2'(opmode_pkg::SLOW_DIV - 1));
					gate_o.wake_timer_enable <= periph_ff[opmode_pkg::BIT_WT_EN];
					gate_o.pwm_buzz_timer_enable <= periph_ff[opmode_pkg::BIT_PB_EN];
					gate_o.converter_enable <= periph_ff[opmode_pkg::BIT_CONV_EN] && (nxt_state != opmode_pkg::ST_GREEN);
				end
			endcase
		end
	end

	chk_down_osc_off: assert property (@(posedge clock_i) disable iff (rst_i)
		state_ff == opmode_pkg::ST_DOWN |-> osc_en_o == '0 && !gate_o.cpu_run)
		else $error("oscillator running in power down");
	// The warm-up counter bounds the stay in warm-up, so no long delay range is needed.
	chk_warm_bounded: assert property (@(posedge clock_i) disable iff (rst_i)
		state_ff == opmode_pkg::ST_WARM |-> warm_ff < warm_len)
		else $error("warm-up overran its count");
	chk_down_wake_normal: assert property (@(posedge clock_i) disable iff (rst_i)
		warm_done |=> state_ff == opmode_pkg::ST_NORMAL)
		else $error("power down wake did not reach normal");
	chk_sleep_cleared: assert property (@(posedge clock_i) disable iff (rst_i)
		wake_down |=> !sleep_ff)
		else $error("sleep request not cleared");
	chk_green_cleared: assert property (@(posedge clock_i) disable iff (rst_i)
		wake_green |=> !green_ff)
		else $error("green request not cleared");
	chk_green_return: assert property (@(posedge clock_i) disable iff (rst_i)
		wake_green && green_from_slow_ff |=> state_ff == opmode_pkg::ST_SLOW)
		else $error("green wake returned to wrong mode");
	chk_green_stays: assert property (@(posedge clock_i) disable iff (rst_i)
		state_ff == opmode_pkg::ST_GREEN && !port_change && !wake_timer_ovf_i |=> state_ff == opmode_pkg::ST_GREEN)
		else $error("green left without wake source");
	chk_down_only_port: assert property (@(posedge clock_i) disable iff (rst_i)
		state_ff == opmode_pkg::ST_DOWN && !port_change |=> state_ff == opmode_pkg::ST_DOWN)
		else $error("power down left without port change");
	chk_slow_high_on: assert property (@(posedge clock_i) disable iff (rst_i)
		state_ff == opmode_pkg::ST_SLOW && !high_stop_ff && !sleep_ff |=> osc_en_o.ext_high_osc)
		else $error("slow mode stopped high oscillator");
	chk_warm_rc_len: assert property (@(posedge clock_i) disable iff (rst_i)
		$rose(state_ff == opmode_pkg::ST_WARM) && !periph_ff[opmode_pkg::BIT_XTAL] |-> state_ff == opmode_pkg::ST_WARM [*8])
		else $error("warm-up too short");
endmodule
`default_nettype wire

// ==== dv/test_operating_mode_controller.sv ====
// Self-checking bench for the operating-mode controller.
// Assumes the Avalon-MM slave of the design and a 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_operating_mode_controller;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [7:0] wake_port_i = 8'h5a;
	logic wake_timer_ovf_i = 1'b0;
	logic low_rc_tick_i = 1'b0;
	opmode_pkg::osc_en_t osc_en_o;
	opmode_pkg::gate_t gate_o;
	logic [4:0] mode_o;
	logic [31:0] q;
	int num_errors = 0;
	int checks_done = 0;
	int ticks;
	operating_mode_controller #(.PORT_W(8), .WARM_XTAL_CYC(16)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .wake_port_i(wake_port_i), .wake_timer_ovf_i(wake_timer_ovf_i),
		.low_rc_tick_i(low_rc_tick_i), .osc_en_o(osc_en_o), .gate_o(gate_o), .mode_o(mode_o));
	always #50 clock_i = ~clock_i;
	task automatic stop_test();
		$display("Checks %0d, errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One Avalon transfer; the request holds until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clock_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge clock_i);
			n++;
			if (n > 20) begin
				num_errors++;
				stop_test();
			end
		end while (avs_waitrequest_o !== 1'b0);
		r = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [3:0] a);
		bus(1'b0, a, 32'h0000_0000, q);
	endtask
	task automatic mode_is(input logic [4:0] exp);
		repeat (2) @(negedge clock_i);
		check("mode", mode_o, exp);
	endtask
	task automatic pulse_ovf();
		@(posedge clock_i);
		wake_timer_ovf_i <= 1'b1;
		@(posedge clock_i);
		wake_timer_ovf_i <= 1'b0;
	endtask
	task automatic port_flip();
		@(posedge clock_i);
		wake_port_i <= ~wake_port_i;
	endtask
	// Warm-up must still hold len - 4 cycles after it is seen, then normal mode resumes within 8 more.
	task automatic warm(input int len);
		int n;
		mode_is(5'h10);
		repeat (len - 4) @(negedge clock_i);
		check("warm held", mode_o, 5'h10);
		n = 0;
		while (mode_o !== 5'h01 && n < 8) begin
			n++;
			@(negedge clock_i);
		end
		check("warm end", mode_o, 5'h01);
	endtask
	initial begin
		#2_000_000;
		num_errors++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge clock_i);
		rst_i <= 1'b0;
		mode_is(5'h01);
		check("osc reset", osc_en_o, 3'h7);
		rd(opmode_pkg::ADDR_OSC_MODE);
		check("osc reg reset", q, 32'h0000_0000);
		rd(opmode_pkg::ADDR_STATUS);
		check("status", q, 32'h0000_0001);
		wr(4'h5, 32'h0000_00ff);
		rd(4'h5);
		check("unmapped", q, 32'h0000_0000);
		wr(opmode_pkg::ADDR_PERIPH, 32'h0000_0007);
		rd(opmode_pkg::ADDR_PERIPH);
		check("periph", q, 32'h0000_0007);
		check("gate normal", gate_o, 5'h1f);
		wr(opmode_pkg::ADDR_OSC_MODE, 32'h0000_0004);
		mode_is(5'h02);
		check("high osc in slow", osc_en_o.ext_high_osc, 1'b1);
		ticks = 0;
		repeat (8) begin
			@(posedge clock_i);
			low_rc_tick_i <= 1'b1;
			@(posedge clock_i);
			low_rc_tick_i <= 1'b0;
			repeat (3) begin
				@(negedge clock_i);
				if (gate_o.cpu_tick === 1'b1) ticks++;
			end
		end
		check("slow ticks", ticks, 2);
		wr(opmode_pkg::ADDR_OSC_MODE, 32'h0000_0006);
		mode_is(5'h02);
		check("osc high stop", osc_en_o, 3'h1);
		wr(opmode_pkg::ADDR_OSC_MODE, 32'h0000_0016);
		mode_is(5'h08);
		check("green cpu", gate_o.cpu_run, 1'b0);
		check("green timer", gate_o.wake_timer_enable, 1'b1);
		check("green pwm", gate_o.pwm_buzz_timer_enable, 1'b1);
		check("green conv", gate_o.converter_enable, 1'b0);
		check("green low rc", osc_en_o.int_low_rc, 1'b1);
		pulse_ovf();
		mode_is(5'h02);
		rd(opmode_pkg::ADDR_OSC_MODE);
		check("green clear", q, 32'h0000_0006);
		wr(opmode_pkg::ADDR_OSC_MODE, 32'h0000_000e);
		mode_is(5'h04);
		check("down osc", osc_en_o, 3'h0);
		check("down gate", gate_o, 5'h00);
		pulse_ovf();
		mode_is(5'h04);
		port_flip();
		warm(opmode_pkg::WARM_RC);
		rd(opmode_pkg::ADDR_OSC_MODE);
		check("sleep clear", q, 32'h0000_0000);
		wr(opmode_pkg::ADDR_OSC_MODE, 32'h0000_0010);
		mode_is(5'h08);
		port_flip();
		mode_is(5'h01);
		wr(opmode_pkg::ADDR_PERIPH, 32'h0000_000f);
		wr(opmode_pkg::ADDR_OSC_MODE, 32'h0000_0002);
		mode_is(5'h04);
		port_flip();
		warm(16);
		stop_test();
	end
endmodule
`default_nettype wire
